// ### prd_decoder.sv
`timescale 1ns/1ps
`include "prd_consts.svh"

module prd_decoder
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              host_req,
    input  wire logic              host_we,
    input  wire logic [7:0]        host_addr,
    input  wire logic [7:0]        host_wdata,
    output logic                   host_ack,
    output logic [7:0]             host_rdata,
    output logic [7:0]             page_sel,
    output logic                   grp_req,
    output logic                   grp_we,
    output prd_pkg::prd_grp_t      grp_sel,
    output logic [3:0]             grp_port,
    output logic [7:0]             grp_addr,
    output logic [7:0]             grp_wdata,
    input  wire logic              grp_ack,
    input  wire logic [7:0]        grp_rdata,
    input  wire logic [7:0]        status_src
);
    import prd_pkg::*;

    // Masks held as typed constants so that single bits can be picked
    localparam logic [7:0] ST_RO      = `PRD_ST_RO_MASK;
    localparam logic [7:0] ST_LH      = `PRD_ST_LH_MASK;
    localparam logic [7:0] ST_LL      = `PRD_ST_LL_MASK;
    localparam logic [7:0] ST_SC      = `PRD_ST_SC_MASK;
    localparam logic [7:0] ST_FH      = `PRD_ST_FH_MASK;
    localparam logic [7:0] ST_FL      = `PRD_ST_FL_MASK;
    localparam logic [4:0] WAIT_LIMIT = 5'(`PRD_GRP_WAIT_CYC);

    prd_regs_t   r_q;
    prd_regs_t   r_d;
    prd_grp_t    map_grp;
    logic [3:0]  map_port;
    logic        take;
    logic        is_global;
    logic        is_page_reg;
    logic        is_status;
    logic        is_spi_data;
    logic        status_rd;
    logic [7:0]  status_next;
    logic [7:0]  status_view;

    // Decode of the currently selected page
    prd_page_map u_map
    (
        .page (r_q.page),
        .grp  (map_grp),
        .port (map_port)
    );

    // Request classification; a request while waiting is ignored
    assign take        = host_req && (r_q.state == ST_IDLE);
    assign is_global   = host_addr >= `PRD_GLOBAL_BASE;
    assign is_page_reg = host_addr == `PRD_PAGE_ADDR;
    assign is_status   = host_addr == `PRD_STATUS_ADDR;
    assign is_spi_data = is_global && (host_addr <= `PRD_SPI_DATA_LAST);
    assign status_rd   = take && !host_we && is_status;

    // Per-bit access types of the global status byte
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_stat
            logic held;
            assign held = r_q.status[gi];
            // Latched bits: the capture wins over a read in the same cycle
            assign status_next[gi] =
                ST_LL[gi] ? (status_src[gi] &
                             (held | status_rd)) :
                (ST_LH[gi] | ST_SC[gi]) ?
                            (status_src[gi] |
                             (held & ~status_rd)) :
                1'b0;
            assign status_view[gi] =
                ST_FH[gi] ? 1'b1 :
                ST_FL[gi] ? 1'b0 :
                ST_RO[gi] ? status_src[gi] :
                held;
        end
    endgenerate

    // Next state of the whole block
    always_comb
    begin
        r_d          = r_q;
        r_d.host_ack = 1'b0;
        r_d.grp_req  = 1'b0;
        r_d.status   = status_next;
        unique case (r_q.state)
            ST_IDLE:
            begin
                if (take && is_global)
                begin
                    // Global block answers at once on any page, except F0h to F7h, which wait for the global group
                    r_d.host_ack   = 1'b1;
                    r_d.host_rdata = `PRD_ZERO_BYTE;
                    if (is_page_reg)
                    begin
                        if (host_we)
                            r_d.page = host_wdata;
                        r_d.host_rdata = r_q.page;
                    end
                    else if (is_status)
                        r_d.host_rdata = status_view;
                    else if (is_spi_data)
                    begin
                        r_d.host_ack  = 1'b0;
                        // Old read data stands until the group answers
                        r_d.host_rdata = r_q.host_rdata;
                        r_d.grp_req   = 1'b1;
                        r_d.grp_we    = host_we;
                        r_d.grp_sel   = GRP_GLOBAL;
                        r_d.grp_port  = `PRD_PORT_NONE;
                        r_d.grp_addr  = host_addr;
                        r_d.grp_wdata = host_wdata;
                        r_d.wait_cnt  = `PRD_CNT_ZERO;
                        r_d.state     = ST_WAIT;
                    end
                end
                else if (take && (map_grp == GRP_NONE))
                begin
                    // Reserved page: zero, no forward, no effect
                    r_d.host_ack   = 1'b1;
                    r_d.host_rdata = `PRD_ZERO_BYTE;
                end
                else if (take)
                begin
                    // Forward into the selected page
                    r_d.grp_req   = 1'b1;
                    r_d.grp_we    = host_we;
                    r_d.grp_sel   = map_grp;
                    r_d.grp_port  = map_port;
                    r_d.grp_addr  = host_addr;
                    r_d.grp_wdata = host_wdata;
                    r_d.wait_cnt  = `PRD_CNT_ZERO;
                    r_d.state     = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // A silent group must not hang the host, so time it out
                r_d.wait_cnt = r_q.wait_cnt + `PRD_CNT_ONE;
                if (grp_ack)
                begin
                    r_d.host_ack   = 1'b1;
                    r_d.host_rdata = grp_rdata;
                    r_d.state      = ST_IDLE;
                end
                else if (r_q.wait_cnt == 5'(`PRD_GRP_WAIT_CYC))
                begin
                    r_d.host_ack   = 1'b1;
                    r_d.host_rdata = `PRD_ZERO_BYTE;
                    r_d.state      = ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_q            <= '0;
            r_q.state      <= ST_IDLE;
            r_q.page       <= `PRD_PAGE_RESET;
            r_q.status     <= `PRD_ST_RESET;
            r_q.grp_sel    <= GRP_NONE;
        end
        else
            r_q <= r_d;
    end

    // Outputs straight from flip-flops
    assign host_ack   = r_q.host_ack;
    assign host_rdata = r_q.host_rdata;
    assign page_sel   = r_q.page;
    assign grp_req    = r_q.grp_req;
    assign grp_we     = r_q.grp_we;
    assign grp_sel    = r_q.grp_sel;
    assign grp_port   = r_q.grp_port;
    assign grp_addr   = r_q.grp_addr;
    assign grp_wdata  = r_q.grp_wdata;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic fwd_take;
    assign fwd_take = take && !is_global && (map_grp != GRP_NONE);

    sequence s_fwd;
        fwd_take ##1 grp_req;
    endsequence

    sequence s_answered;
        ##[1:17] host_ack;
    endsequence

    a_page_write: assert property (take && host_we && is_page_reg
        |=> page_sel == $past(host_wdata))
        else $error("page register not loaded");

    a_page_hold: assert property (!(take && host_we && is_page_reg)
        |=> $stable(page_sel))
        else $error("page changed without a page write");

    a_fwd_addr: assert property (fwd_take
        |=> grp_req && grp_addr == $past(host_addr)
            && grp_we == $past(host_we))
        else $error("forwarded access has wrong address");

    a_fwd_answer: assert property (s_fwd |-> s_answered)
        else $error("forwarded access never answered");

    a_global_local: assert property (take && is_global && !is_spi_data
        |=> host_ack && !grp_req)
        else $error("global register access was forwarded");

    a_rsvd_zero: assert property (take && !is_global
        && map_grp == GRP_NONE
        |=> host_ack && host_rdata == `PRD_ZERO_BYTE && !grp_req)
        else $error("reserved page did not read zero");

    a_phy_port: assert property (fwd_take
        && r_q.page >= `PRD_PG_PHY_FIRST && r_q.page <= `PRD_PG_PHY_LAST
        |=> grp_sel == GRP_COPPER_PHY
            && grp_port == $past(r_q.page[3:0]))
        else $error("copper PHY page routed to wrong port");

    a_stats_grp: assert property (fwd_take
        && r_q.page == 8'h28
        |=> grp_sel == GRP_STATS && grp_port == 4'h8)
        else $error("last statistics page misrouted");

    a_lh_sticky: assert property (status_src[2] && !status_rd
        |=> r_q.status[2] ##1 (r_q.status[2] || $past(status_rd)))
        else $error("latched high bit lost");

    a_fixed_bits: assert property (status_rd
        |=> host_rdata[6] && !host_rdata[7])
        else $error("fixed status bits read wrong");

    a_ll_release: assert property (status_rd && status_src[4]
        |=> r_q.status[4])
        else $error("latched low bit not released by read");

    a_sc_clear: assert property (status_rd && !status_src[5]
        |=> !r_q.status[5])
        else $error("clear on read bit survived a read");

    a_status_view: assert property (status_rd
        |=> host_rdata[1:0] == $past(status_src[1:0]))
        else $error("read-only status bits not live");

    // Host side: answers, holds and refusals
    a_page_read: assert property (take && !host_we && is_page_reg
        |=> host_rdata == $past(page_sel))
        else $error("page register read back wrong");

    a_no_ack_idle: assert property (r_q.state == ST_IDLE && !take
        |=> !host_ack)
        else $error("answer without a request");

    a_rdata_hold: assert property (!host_ack
        |-> $stable(host_rdata))
        else $error("read data moved without an answer");

    // Group side and timeout
    a_grp_pulse: assert property (grp_req
        |=> !grp_req)
        else $error("forward strobe longer than one cycle");

    a_wait_ignore: assert property (r_q.state == ST_WAIT && !grp_ack
        && r_q.wait_cnt != WAIT_LIMIT
        |=> !host_ack && !grp_req && r_q.state == ST_WAIT)
        else $error("access while waiting was not ignored");

    a_grp_return: assert property (r_q.state == ST_WAIT && grp_ack
        |=> host_ack && host_rdata == $past(grp_rdata))
        else $error("group answer not passed to host");

    sequence s_expired;
        r_q.state == ST_WAIT && !grp_ack && r_q.wait_cnt == WAIT_LIMIT;
    endsequence

    a_timeout_zero: assert property (s_expired
        |=> host_ack && host_rdata == `PRD_ZERO_BYTE)
        else $error("silent group did not time out to zero");

    a_spi_global: assert property (take && is_spi_data
        |=> grp_req && grp_sel == GRP_GLOBAL
            && grp_port == `PRD_PORT_NONE)
        else $error("global data byte not forwarded as global");

    a_port_none: assert property (fwd_take && map_grp != GRP_COPPER_PHY
        && map_grp != GRP_STATS
        |=> grp_port == `PRD_PORT_NONE)
        else $error("port index set on a shared page");

endmodule

// ### prd_consts.svh
// How it works
// - The host picks a page by writing its number to the page register at 0xFF, and that page stays selected until the host writes another or reset loads 00h.
// - Each access below the global block on a listed page goes to the register at that byte address inside the selected page; reserved pages read zero.
// - Every register bit has one access type (read-write, read-only, latched high, latched low, fixed high, fixed low, clear on read).
// - Pages 00h, 01h, 02h and 03h select control, status, management/mirroring and interrupt control.
// - Page 05h selects the address table and VLAN table access registers.
// - Pages 10h to 17h select the copper PHY of ports 0 to 7, one page per port in order.
// - Pages 20h to 28h select the statistics counters of one port each.
// - Pages 30h, 31h, 32h and 34h select QoS, port VLAN, trunking and 802.1Q VLAN.
// - Pages 36h, 40h, 41h, 42h and 43h select attack prevention, jumbo, storm, authentication and spanning tree.
// - Pages 70h, 71h and 72h select snapshot control, per-port snapshot control and loop detection.
// - Page 88h selects the management port external PHY; 90h, 91h and 92h select time sync, remarking and EEE.
// - Addresses F0h to FFh reach the same global registers whatever page is selected.
`ifndef PRD_CONSTS_SVH
`define PRD_CONSTS_SVH

// Global block
`define PRD_GLOBAL_BASE      8'hf0
`define PRD_SPI_DATA_LAST    8'hf7
`define PRD_STATUS_ADDR      8'hfe
`define PRD_PAGE_ADDR        8'hff
`define PRD_PAGE_RESET       8'h00
`define PRD_ZERO_BYTE        8'h00

// Page codes
`define PRD_PG_CONTROL       8'h00
`define PRD_PG_STATUS        8'h01
`define PRD_PG_MGMT          8'h02
`define PRD_PG_INTR          8'h03
`define PRD_PG_INTR_ALIAS    8'h04
`define PRD_PG_TABLE         8'h05
`define PRD_PG_PHY_FIRST     8'h10
`define PRD_PG_PHY_LAST      8'h17
`define PRD_PG_STATS_FIRST   8'h20
`define PRD_PG_STATS_LAST    8'h28
`define PRD_PG_QOS           8'h30
`define PRD_PG_PORT_VLAN     8'h31
`define PRD_PG_TRUNK         8'h32
`define PRD_PG_QVLAN         8'h34
`define PRD_PG_ATTACK        8'h36
`define PRD_PG_JUMBO         8'h40
`define PRD_PG_STORM         8'h41
`define PRD_PG_AUTH          8'h42
`define PRD_PG_SPAN          8'h43
`define PRD_PG_SNAP_CTRL     8'h70
`define PRD_PG_PORT_SNAP     8'h71
`define PRD_PG_LOOP          8'h72
`define PRD_PG_EXT_PHY       8'h88
`define PRD_PG_TIME_SYNC     8'h90
`define PRD_PG_REMARK        8'h91
`define PRD_PG_EEE           8'h92
`define PRD_PORT_NONE        4'h0

// Access type of each bit of the global status byte
`define PRD_ST_RO_MASK       8'h03
`define PRD_ST_LH_MASK       8'h0c
`define PRD_ST_LL_MASK       8'h10
`define PRD_ST_SC_MASK       8'h20
`define PRD_ST_FH_MASK       8'h40
`define PRD_ST_FL_MASK       8'h80
`define PRD_ST_RESET         8'h10

// Longest wait for a page group to answer
`define PRD_CLK_NS           40
`define PRD_GRP_WAIT_NS      640
`define PRD_GRP_WAIT_CYC     (`PRD_GRP_WAIT_NS / `PRD_CLK_NS)
`define PRD_CNT_ZERO         5'h00
`define PRD_CNT_ONE          5'h01

`endif

// ### prd_pkg.sv
package prd_pkg;

    typedef enum logic [4:0] {
        GRP_NONE,
        GRP_CONTROL,
        GRP_STATUS,
        GRP_MGMT_MIRROR,
        GRP_INTR,
        GRP_TABLE_ACCESS,
        GRP_COPPER_PHY,
        GRP_STATS,
        GRP_QOS,
        GRP_PORT_VLAN,
        GRP_TRUNK,
        GRP_QVLAN,
        GRP_ATTACK_PREV,
        GRP_JUMBO,
        GRP_STORM,
        GRP_AUTH,
        GRP_SPAN_TREE,
        GRP_SNAP_CTRL,
        GRP_PORT_SNAP,
        GRP_LOOP,
        GRP_EXT_PHY,
        GRP_TIME_SYNC,
        GRP_REMARK,
        GRP_EEE,
        GRP_GLOBAL
    } prd_grp_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_WAIT
    } prd_state_t;

    typedef struct packed {
        prd_state_t  state;
        logic [7:0]  page;
        logic [7:0]  status;
        logic        host_ack;
        logic [7:0]  host_rdata;
        logic        grp_req;
        logic        grp_we;
        prd_grp_t    grp_sel;
        logic [3:0]  grp_port;
        logic [7:0]  grp_addr;
        logic [7:0]  grp_wdata;
        logic [4:0]  wait_cnt;
    } prd_regs_t;

endpackage

// ### prd_page_map.sv
`timescale 1ns/1ps
`include "prd_consts.svh"

module prd_page_map
(
    input  wire logic [7:0]        page,
    output prd_pkg::prd_grp_t      grp,
    output logic [3:0]             port
);
    import prd_pkg::*;

    // Page number to functional group; unlisted codes stay reserved
    always_comb
    begin
        grp  = GRP_NONE;
        port = `PRD_PORT_NONE;
        unique case (page) inside
            `PRD_PG_CONTROL:    grp = GRP_CONTROL;
            `PRD_PG_STATUS:     grp = GRP_STATUS;
            `PRD_PG_MGMT:       grp = GRP_MGMT_MIRROR;
            `PRD_PG_INTR,
            `PRD_PG_INTR_ALIAS: grp = GRP_INTR;
            `PRD_PG_TABLE:      grp = GRP_TABLE_ACCESS;
            [`PRD_PG_PHY_FIRST:`PRD_PG_PHY_LAST]:
            begin
                grp  = GRP_COPPER_PHY;
                port = 4'(page - `PRD_PG_PHY_FIRST);
            end
            [`PRD_PG_STATS_FIRST:`PRD_PG_STATS_LAST]:
            begin
                grp  = GRP_STATS;
                port = 4'(page - `PRD_PG_STATS_FIRST);
            end
            `PRD_PG_QOS:        grp = GRP_QOS;
            `PRD_PG_PORT_VLAN:  grp = GRP_PORT_VLAN;
            `PRD_PG_TRUNK:      grp = GRP_TRUNK;
            `PRD_PG_QVLAN:      grp = GRP_QVLAN;
            `PRD_PG_ATTACK:     grp = GRP_ATTACK_PREV;
            `PRD_PG_JUMBO:      grp = GRP_JUMBO;
            `PRD_PG_STORM:      grp = GRP_STORM;
            `PRD_PG_AUTH:       grp = GRP_AUTH;
            `PRD_PG_SPAN:       grp = GRP_SPAN_TREE;
            `PRD_PG_SNAP_CTRL:  grp = GRP_SNAP_CTRL;
            `PRD_PG_PORT_SNAP:  grp = GRP_PORT_SNAP;
            `PRD_PG_LOOP:       grp = GRP_LOOP;
            `PRD_PG_EXT_PHY:    grp = GRP_EXT_PHY;
            `PRD_PG_TIME_SYNC:  grp = GRP_TIME_SYNC;
            `PRD_PG_REMARK:     grp = GRP_REMARK;
            `PRD_PG_EEE:        grp = GRP_EEE;
            default:            grp = GRP_NONE;
        endcase
    end

endmodule

// ### prd_grp_model.sv
`timescale 1ns/1ps

// Page group stand-in: answers a forwarded access after lat cycles
module prd_grp_model
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              grp_req,
    input  wire logic [7:0]        grp_addr,
    input  wire logic [3:0]        grp_port,
    input  wire prd_pkg::prd_grp_t grp_sel,
    input  wire logic [4:0]        lat,
    output logic                   grp_ack,
    output logic [7:0]             grp_rdata
);
    import prd_pkg::*;

    logic [4:0] cnt_q;

    // Zero latency means never answer, to drive the timeout path
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= 5'h00;
            grp_ack <= 1'b0;
            grp_rdata <= 8'h00;
        end
        else
        begin
            grp_ack <= 1'b0;
            // Released bus toggles so stale data never looks valid
            grp_rdata <= ~grp_rdata;
            if (grp_req)
                cnt_q <= lat;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01)
            begin
                grp_ack <= 1'b1;
                grp_rdata <= grp_addr ^ {grp_port, grp_sel[3:0]};
            end
        end
    end
endmodule

// ### prd_decoder_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("ERROR %s exp %h got %h", nm, e, g); \
        end \
    end

module prd_decoder_bench;
    import prd_pkg::*;

    logic      ref_clk, sys_rst, host_req, host_we, host_ack;
    logic      grp_req, grp_we, grp_ack;
    logic [7:0] host_addr, host_wdata, host_rdata, page_sel;
    logic [7:0] grp_addr, grp_wdata, grp_rdata, status_src;
    logic [3:0] grp_port;
    logic [4:0] lat;
    prd_grp_t   grp_sel;
    int         fails, total_checks, nreq;

    prd_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .host_req(host_req), .host_we(host_we), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack(host_ack),
        .host_rdata(host_rdata), .page_sel(page_sel),
        .grp_req(grp_req), .grp_we(grp_we), .grp_sel(grp_sel),
        .grp_port(grp_port), .grp_addr(grp_addr),
        .grp_wdata(grp_wdata), .grp_ack(grp_ack),
        .grp_rdata(grp_rdata), .status_src(status_src));

    prd_grp_model grp (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .grp_req(grp_req), .grp_addr(grp_addr), .grp_port(grp_port),
        .grp_sel(grp_sel), .lat(lat), .grp_ack(grp_ack),
        .grp_rdata(grp_rdata));

    // Count forwards so dropped accesses can be proven silent
    always @(posedge ref_clk)
        if (grp_req === 1'b1)
            nreq++;

    // One host access; only whole bytes, no reserved bits touched
    task automatic acc(input logic we, input logic [7:0] a, d,
                       output logic [7:0] rd);
        int n;
        @(negedge ref_clk);
        host_req = 1'b1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        @(negedge ref_clk);
        host_req = 1'b0;
        n = 0;
        while (host_ack !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("host_ack", 1'b1, host_ack)
        rd = host_rdata;
    endtask

    task automatic t_rst;
        `CHK("page_sel", 8'h00, page_sel)
        `CHK("host_ack", 1'b0, host_ack)
        `CHK("grp_req", 1'b0, grp_req)
    endtask

    // Select a page, read it back, then read one of its registers
    task automatic t_one(input logic [7:0] pg, input prd_grp_t g,
                         input logic [3:0] pt);
        logic [7:0] rd, a;
        a = {1'b0, pg[6:0]};
        acc(1'b1, 8'hff, pg, rd);
        acc(1'b0, 8'hff, 8'h00, rd);
        `CHK("page", pg, rd)
        acc(1'b0, a, 8'h00, rd);
        `CHK("page_sel", pg, page_sel)
        `CHK("grp_sel", g, grp_sel)
        `CHK("grp_port", pt, grp_port)
        `CHK("grp_addr", a, grp_addr)
        `CHK("grp_we", 1'b0, grp_we)
        `CHK("rdata", a ^ {pt, g[3:0]}, rd)
    endtask

    // Reserved pages answer zero and forward nothing
    task automatic t_res(input logic [7:0] pg);
        logic [7:0] rd;
        int n0;
        acc(1'b1, 8'hff, pg, rd);
        n0 = nreq;
        acc(1'b1, 8'h12, 8'h5a, rd);
        acc(1'b0, 8'h12, 8'h00, rd);
        `CHK("res rdata", 8'h00, rd)
        `CHK("res fwd", n0, nreq)
    endtask

    // Global block looks the same from any page
    task automatic t_glob(input logic [7:0] pg);
        logic [7:0] rd;
        int n0;
        prd_grp_t gg;
        gg = GRP_GLOBAL;
        acc(1'b1, 8'hff, pg, rd);
        acc(1'b0, 8'hf3, 8'h00, rd);
        `CHK("glob sel", GRP_GLOBAL, grp_sel)
        `CHK("glob port", 4'h0, grp_port)
        `CHK("glob rd", 8'hf3 ^ {4'h0, gg[3:0]}, rd)
        n0 = nreq;
        acc(1'b1, 8'hfa, 8'h77, rd);
        acc(1'b0, 8'hfa, 8'h00, rd);
        `CHK("fa rd", 8'h00, rd)
        `CHK("fa fwd", n0, nreq)
        acc(1'b0, 8'hff, 8'h00, rd);
        `CHK("glob page", pg, rd)
    endtask

    // Slow and silent groups: a late answer acks a write, silence reads zero
    task automatic t_slow;
        logic [7:0] rd;
        lat = 5'd12;
        acc(1'b1, 8'hff, 8'h00, rd);
        acc(1'b1, 8'h21, 8'h3c, rd);
        `CHK("grp_we", 1'b1, grp_we)
        `CHK("grp_wdata", 8'h3c, grp_wdata)
        `CHK("grp_addr", 8'h21, grp_addr)
        lat = 5'd0;
        acc(1'b0, 8'h05, 8'h00, rd);
        `CHK("timeout rd", 8'h00, rd)
        lat = 5'd1;
    endtask

    // Status byte access kinds: live, latched high, clear on read, fixed
    task automatic t_stat;
        logic [7:0] rd;
        @(negedge ref_clk);
        status_src = 8'h24;
        @(negedge ref_clk);
        status_src = 8'h02;
        acc(1'b0, 8'hfe, 8'h00, rd);
        `CHK("status 1", 8'h66, rd)
        acc(1'b0, 8'hfe, 8'h00, rd);
        `CHK("status 2", 8'h42, rd)
        // Latched low: reports the low once, then follows a high source
        status_src = 8'h10;
        acc(1'b0, 8'hfe, 8'h00, rd);
        `CHK("status 3", 8'h40, rd)
        acc(1'b0, 8'hfe, 8'h00, rd);
        `CHK("status 4", 8'h50, rd)
        status_src = 8'h00;
        acc(1'b0, 8'hfe, 8'h00, rd);
        `CHK("status 5", 8'h40, rd)
    endtask

    // Reset in mid-run returns the page to its reset value
    task automatic t_mrst;
        logic [7:0] rd;
        acc(1'b1, 8'hff, 8'h42, rd);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_rst();
        acc(1'b0, 8'hff, 8'h00, rd);
        `CHK("page after rst", 8'h00, rd)
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        #200000;
        fails++;
        summarize();
    end

    initial
    begin
        sys_rst = 1'b1;
        host_req = 1'b0;
        host_we = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
        status_src = 8'h00;
        lat = 5'd1;
        fails = 0;
        total_checks = 0;
        nreq = 0;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_rst();
        t_one(8'h00, GRP_CONTROL, 4'h0);
        t_one(8'h01, GRP_STATUS, 4'h0);
        t_one(8'h02, GRP_MGMT_MIRROR, 4'h0);
        t_one(8'h03, GRP_INTR, 4'h0);
        t_one(8'h04, GRP_INTR, 4'h0);
        t_one(8'h05, GRP_TABLE_ACCESS, 4'h0);
        for (int i = 0; i < 8; i++)
            t_one(8'h10 + 8'(i), GRP_COPPER_PHY, 4'(i));
        for (int i = 0; i < 9; i++)
            t_one(8'h20 + 8'(i), GRP_STATS, 4'(i));
        t_one(8'h30, GRP_QOS, 4'h0);
        t_one(8'h31, GRP_PORT_VLAN, 4'h0);
        t_one(8'h32, GRP_TRUNK, 4'h0);
        t_one(8'h34, GRP_QVLAN, 4'h0);
        t_one(8'h36, GRP_ATTACK_PREV, 4'h0);
        t_one(8'h40, GRP_JUMBO, 4'h0);
        t_one(8'h41, GRP_STORM, 4'h0);
        t_one(8'h42, GRP_AUTH, 4'h0);
        t_one(8'h43, GRP_SPAN_TREE, 4'h0);
        t_one(8'h70, GRP_SNAP_CTRL, 4'h0);
        t_one(8'h71, GRP_PORT_SNAP, 4'h0);
        t_one(8'h72, GRP_LOOP, 4'h0);
        t_one(8'h88, GRP_EXT_PHY, 4'h0);
        t_one(8'h90, GRP_TIME_SYNC, 4'h0);
        t_one(8'h91, GRP_REMARK, 4'h0);
        t_one(8'h92, GRP_EEE, 4'h0);
        t_res(8'h06);
        t_res(8'h33);
        t_res(8'ha1);
        t_glob(8'h30);
        t_glob(8'h17);
        t_slow();
        t_stat();
        t_mrst();
        summarize();
    end
endmodule
